// *** logic/vss_top.sv ***
// Voltage stabilization select: AXI4-Lite registers, transition waits and
// the halt flush delay. Assumes one clock, inputs synchronous to it.
//
// Overview of operation
// - Code 00: down uses main time, entry under 1 us, exit alt time.
// - Code 01: down uses main time, entry and exit use alt time.
// - Code 10: down waits zero, entry under 1 us, exit alt time.
// - Code 11: down, entry and exit all use main time.
// - Halt flush delay is read-write at bits 25:19, reset to zero.
// - Flush delay applies only while flush on halt is enabled.
// - On the earliest revision the flush delay field is reserved.
// - Upward transitions always use the dedicated up time.
`default_nettype none

module vss_top
  import vss_pkg::*;
#(
  parameter int REVISION = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [vss_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [vss_pkg::DW-1:0] s_axi_wdata,
  input wire logic [vss_pkg::NBYTES-1:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [vss_pkg::AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [vss_pkg::DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic trans_req,
  input wire vss_pkg::vss_event_t trans_kind,
  output logic trans_ready,
  output logic trans_busy,
  output logic trans_done,
  input wire logic halt_req,
  output logic flush_go,
  output logic [vss_pkg::SEL_W-1:0] stabilization_select,
  output logic [vss_pkg::FLUSH_W-1:0] halt_flush_delay
);

  // Write channel state
  logic aw_have_ff, nxt_aw_have;
  logic [AW-1:0] awaddr_ff, nxt_awaddr;
  logic w_have_ff, nxt_w_have;
  logic [DW-1:0] wdata_ff, nxt_wdata;
  logic [NBYTES-1:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic do_write;
  // Read channel state
  logic rvalid_ff, nxt_rvalid;
  logic [DW-1:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  // Configuration state
  logic [SEL_W-1:0] sel_ff, nxt_sel;
  logic [FLUSH_W-1:0] flush_dly_ff, nxt_flush_dly;
  logic flush_en_ff, nxt_flush_en;
  logic [TW-1:0] main_time_ff, nxt_main_time;
  logic [TW-1:0] alt_time_ff, nxt_alt_time;
  logic [TW-1:0] up_time_ff, nxt_up_time;
  // Datapath
  logic [DW-1:0] wmask;
  logic [DW-1:0] cfg_word;
  logic [DW-1:0] ctrl_word;
  logic [DW-1:0] stat_word;
  logic [TW-1:0] trans_wait;
  logic [TW-1:0] flush_wait;
  logic trans_load;
  logic flush_load;
  logic flush_busy;

  // Byte enables widened to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < NBYTES; gi++) begin : g_mask
      assign wmask[gi*8 +: 8] = {8{wstrb_ff[gi]}};
    end
  endgenerate

  // Readback words; reserved bits read zero
  always_comb begin
    cfg_word = ZERO_WORD;
    cfg_word[SEL_LSB +: SEL_W] = sel_ff;
    cfg_word[FLUSH_LSB +: FLUSH_W] = flush_dly_ff;
    ctrl_word = ZERO_WORD;
    ctrl_word[FLUSH_EN_BIT] = flush_en_ff;
    stat_word = ZERO_WORD;
    stat_word[STAT_TBUSY_BIT] = trans_busy;
    stat_word[STAT_FBUSY_BIT] = flush_busy;
  end

  // Address and data taken in either order, then one write, then response
  assign s_axi_awready = ce && !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = ce && !w_have_ff && !bvalid_ff;
  assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;

  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_have = w_have_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_have = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_have = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      case (awaddr_ff)
        OFF_CFG, OFF_CTRL, OFF_MAIN_TIME, OFF_ALT_TIME, OFF_UP_TIME,
        OFF_STATUS: nxt_bresp = RESP_OKAY;
        default: nxt_bresp = RESP_SLVERR;
      endcase
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_have_ff <= 1'b0;
      awaddr_ff <= '0;
      w_have_ff <= 1'b0;
      wdata_ff <= ZERO_WORD;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (ce) begin
      aw_have_ff <= nxt_aw_have;
      awaddr_ff <= nxt_awaddr;
      w_have_ff <= nxt_w_have;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  // Register updates; status writes are accepted and dropped
  always_comb begin
    logic [DW-1:0] merged;
    merged = ZERO_WORD;
    nxt_sel = sel_ff;
    nxt_flush_dly = flush_dly_ff;
    nxt_flush_en = flush_en_ff;
    nxt_main_time = main_time_ff;
    nxt_alt_time = alt_time_ff;
    nxt_up_time = up_time_ff;
    if (do_write) begin
      case (awaddr_ff)
        OFF_CFG: begin
          merged = (cfg_word & ~wmask) | (wdata_ff & wmask);
          nxt_sel = merged[SEL_LSB +: SEL_W];
          // Earliest silicon keeps the field stuck at zero
          if (REVISION != REV_EARLIEST) begin
            nxt_flush_dly = merged[FLUSH_LSB +: FLUSH_W];
          end
        end
        OFF_CTRL: begin
          merged = (ctrl_word & ~wmask) | (wdata_ff & wmask);
          nxt_flush_en = merged[FLUSH_EN_BIT];
        end
        OFF_MAIN_TIME: begin
          merged = ({16'h0000, main_time_ff} & ~wmask) | (wdata_ff & wmask);
          nxt_main_time = merged[TW-1:0];
        end
        OFF_ALT_TIME: begin
          merged = ({16'h0000, alt_time_ff} & ~wmask) | (wdata_ff & wmask);
          nxt_alt_time = merged[TW-1:0];
        end
        OFF_UP_TIME: begin
          merged = ({16'h0000, up_time_ff} & ~wmask) | (wdata_ff & wmask);
          nxt_up_time = merged[TW-1:0];
        end
        default: merged = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_ff <= RST_SEL;
      flush_dly_ff <= RST_FLUSH;
      flush_en_ff <= RST_FLUSH_EN;
      main_time_ff <= RST_MAIN_TIME;
      alt_time_ff <= RST_ALT_TIME;
      up_time_ff <= RST_UP_TIME;
    end else if (ce) begin
      sel_ff <= nxt_sel;
      flush_dly_ff <= nxt_flush_dly;
      flush_en_ff <= nxt_flush_en;
      main_time_ff <= nxt_main_time;
      alt_time_ff <= nxt_alt_time;
      up_time_ff <= nxt_up_time;
    end
  end

  // Read channel; one read outstanding, answer one cycle after the take
  assign s_axi_arready = ce && !rvalid_ff;
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      case (s_axi_araddr)
        OFF_CFG: nxt_rdata = cfg_word;
        OFF_CTRL: nxt_rdata = ctrl_word;
        OFF_MAIN_TIME: nxt_rdata = {16'h0000, main_time_ff};
        OFF_ALT_TIME: nxt_rdata = {16'h0000, alt_time_ff};
        OFF_UP_TIME: nxt_rdata = {16'h0000, up_time_ff};
        OFF_STATUS: nxt_rdata = stat_word;
        default: begin
          nxt_rdata = ZERO_WORD;
          nxt_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= ZERO_WORD;
      rresp_ff <= RESP_OKAY;
    end else if (ce) begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  // Wait chosen from the selection code and transition kind
  vss_wait_sel u_sel (
    .stabilization_select(sel_ff),
    .kind(trans_kind),
    .main_stabilization_time(main_time_ff),
    .alt_stabilization_time(alt_time_ff),
    .up_stabilization_time(up_time_ff),
    .wait_cycles(trans_wait)
  );

  // New requests are refused while a wait is still running
  assign trans_load = ce && trans_req && !trans_busy;
  assign trans_ready = !trans_busy;
  vss_countdown u_trans (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .load(trans_load),
    .value(trans_wait),
    .busy(trans_busy),
    .done(trans_done)
  );
  // Halt flush only starts while flush on halt is on; a running wait still finishes if it is turned off
  assign flush_load = ce && halt_req && flush_en_ff && !flush_busy;
  assign flush_wait = {{(TW - FLUSH_W){1'b0}}, flush_dly_ff};
  vss_countdown u_flush (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .load(flush_load),
    .value(flush_wait),
    .busy(flush_busy),
    .done(flush_go)
  );
  assign stabilization_select = sel_ff;
  assign halt_flush_delay = flush_dly_ff;
  // Checks on the wait chosen when a transition is taken, on busy, and on the flush delay
  a_entry_short_wait: assert property (@(posedge clk) disable iff (!nrst)
    trans_load && sel_ff == SEL_MAIN_SHORT_ALT && trans_kind == EV_ALT_ENTRY
    |-> trans_wait == SHORT_WAIT_CYC)
    else $error("entry wait with code 00 is not the short wait");
  a_code01_alt_wait: assert property (@(posedge clk) disable iff (!nrst)
    trans_load && sel_ff == SEL_MAIN_ALT_ALT && trans_kind != EV_DOWN
    && trans_kind != EV_UP |-> trans_wait == alt_time_ff)
    else $error("code 01 alt transition does not use alt time");
  a_code10_zero_down: assert property (@(posedge clk) disable iff (!nrst)
    trans_load && sel_ff == SEL_ZERO_SHORT_ALT && trans_kind == EV_DOWN
    ##1 ce |=> trans_done)
    else $error("code 10 down transition did not finish at once");
  a_code11_main_wait: assert property (@(posedge clk) disable iff (!nrst)
    trans_load && sel_ff == SEL_MAIN_ALL && trans_kind != EV_UP
    |-> trans_wait == main_time_ff)
    else $error("code 11 transition does not use main time");
  a_up_dedicated: assert property (@(posedge clk) disable iff (!nrst)
    trans_load && trans_kind == EV_UP |-> trans_wait == up_time_ff)
    else $error("upward transition does not use up time");
  a_trans_held_busy: assert property (@(posedge clk) disable iff (!nrst)
    trans_load && trans_wait > TIMER_ONE
    |=> trans_busy && !trans_done ##1 trans_busy && !trans_done)
    else $error("transition completed before its wait ran out");
  a_flush_field_rw: assert property (@(posedge clk) disable iff (!nrst)
    ce && do_write && awaddr_ff == OFF_CFG && wstrb_ff == 4'hf
    && REVISION != REV_EARLIEST
    |=> flush_dly_ff == $past(wdata_ff[FLUSH_LSB +: FLUSH_W]))
    else $error("flush delay field did not take the written value");
  a_flush_needs_en: assert property (@(posedge clk) disable iff (!nrst)
    halt_req && !flush_en_ff && !flush_busy |=> !flush_busy)
    else $error("flush wait started with flush on halt disabled");
  a_early_rev_dead: assert property (@(posedge clk) disable iff (!nrst)
    REVISION == REV_EARLIEST |-> flush_dly_ff == RST_FLUSH)
    else $error("flush delay field moved on the earliest revision");
endmodule

`default_nettype wire

// *** logic/vss_pkg.sv ***
// Constants, register map and event codes for the stabilization select block.
// Assumes a single 10 MHz clock domain and an AXI4-Lite register port.
`default_nettype none

package vss_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SHORT_WAIT_NS = 1000; // Entry wait must stay under this
  // Longest time rounds down, and strictly below the figure
  localparam int SHORT_WAIT_CYC_I = SHORT_WAIT_NS / CLK_PERIOD_NS - 1;
  localparam int TW = 16;
  localparam logic [TW-1:0] SHORT_WAIT_CYC = TW'(SHORT_WAIT_CYC_I);
  localparam logic [TW-1:0] ZERO_WAIT = 16'h0000;
  localparam logic [TW-1:0] TIMER_ONE = 16'h0001;

  // Bus geometry
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int NBYTES = DW / 8;

  // Register byte offsets
  localparam logic [AW-1:0] OFF_CFG = 8'h00;
  localparam logic [AW-1:0] OFF_CTRL = 8'h04;
  localparam logic [AW-1:0] OFF_MAIN_TIME = 8'h08;
  localparam logic [AW-1:0] OFF_ALT_TIME = 8'h0c;
  localparam logic [AW-1:0] OFF_UP_TIME = 8'h10;
  localparam logic [AW-1:0] OFF_STATUS = 8'h14;

  // Field layout
  localparam int SEL_LSB = 27;
  localparam int SEL_W = 2;
  localparam int FLUSH_LSB = 19;
  localparam int FLUSH_W = 7;
  localparam int FLUSH_EN_BIT = 0;
  localparam int STAT_TBUSY_BIT = 0;
  localparam int STAT_FBUSY_BIT = 1;

  // Selection codes
  localparam logic [SEL_W-1:0] SEL_MAIN_SHORT_ALT = 2'h0;
  localparam logic [SEL_W-1:0] SEL_MAIN_ALT_ALT = 2'h1;
  localparam logic [SEL_W-1:0] SEL_ZERO_SHORT_ALT = 2'h2;
  localparam logic [SEL_W-1:0] SEL_MAIN_ALL = 2'h3;

  // Reset values
  localparam logic [SEL_W-1:0] RST_SEL = 2'h0;
  localparam logic [FLUSH_W-1:0] RST_FLUSH = 7'h00;
  localparam logic RST_FLUSH_EN = 1'h0;
  localparam logic [TW-1:0] RST_MAIN_TIME = 16'h0064;
  localparam logic [TW-1:0] RST_ALT_TIME = 16'h0032;
  localparam logic [TW-1:0] RST_UP_TIME = 16'h0064;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DW-1:0] ZERO_WORD = 32'h0000_0000;

  // Earliest silicon revision, where the flush delay field is dead
  localparam int REV_EARLIEST = 0;

  // Kind of voltage transition requested
  typedef enum logic [1:0] {
    EV_DOWN,
    EV_UP,
    EV_ALT_ENTRY,
    EV_ALT_EXIT
  } vss_event_t;

endpackage

`default_nettype wire

// *** logic/vss_wait_sel.sv ***
// Picks the stabilization wait for one transition kind and selection code.
// Purely combinational; the caller loads the result into a countdown.
`default_nettype none

module vss_wait_sel
  import vss_pkg::*;
(
  input wire logic [vss_pkg::SEL_W-1:0] stabilization_select,
  input wire vss_pkg::vss_event_t kind,
  input wire logic [vss_pkg::TW-1:0] main_stabilization_time,
  input wire logic [vss_pkg::TW-1:0] alt_stabilization_time,
  input wire logic [vss_pkg::TW-1:0] up_stabilization_time,
  output logic [vss_pkg::TW-1:0] wait_cycles
);

  // Upward moves ignore the selection code entirely
  always_comb begin
    wait_cycles = main_stabilization_time;
    case (kind)
      EV_UP: wait_cycles = up_stabilization_time;
      EV_DOWN: begin
        if (stabilization_select == SEL_ZERO_SHORT_ALT) begin
          wait_cycles = ZERO_WAIT;
        end else begin
          wait_cycles = main_stabilization_time;
        end
      end
      EV_ALT_ENTRY: begin
        case (stabilization_select)
          SEL_MAIN_ALT_ALT: wait_cycles = alt_stabilization_time;
          SEL_MAIN_ALL: wait_cycles = main_stabilization_time;
          default: wait_cycles = SHORT_WAIT_CYC;
        endcase
      end
      EV_ALT_EXIT: begin
        if (stabilization_select == SEL_MAIN_ALL) begin
          wait_cycles = main_stabilization_time;
        end else begin
          wait_cycles = alt_stabilization_time;
        end
      end
      default: wait_cycles = main_stabilization_time;
    endcase
  end

endmodule

`default_nettype wire

// *** logic/vss_countdown.sv ***
// Countdown that holds busy from a load until the loaded count has run out.
// A load of N gives done N+1 cycles after the load edge; ce freezes it.
`default_nettype none

module vss_countdown
  import vss_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic load,
  input wire logic [vss_pkg::TW-1:0] value,
  output logic busy,
  output logic done
);

  logic [TW-1:0] cnt_ff;
  logic [TW-1:0] nxt_cnt;
  logic busy_ff;
  logic nxt_busy;
  logic done_ff;
  logic nxt_done;

  // Next count; a load while busy is ignored here as well as by the caller
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (load && !busy_ff) begin
      nxt_cnt = value;
      nxt_busy = 1'b1;
    end else if (busy_ff) begin
      if (cnt_ff == ZERO_WAIT) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - TIMER_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= ZERO_WAIT;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;

endmodule

`default_nettype wire

// *** dv/tb_vss_top.sv ***
// Self-checking bench for the stabilization select block.
// Assumes the design package and modules compile first; one 10 MHz clock.
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("mismatch %s exp %0h got %0h", what, exp, got); \
    end \
  end

module tb_vss_top
  import vss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Small wait times keep each transition short
  localparam int MAINT = 5;
  localparam int ALTT = 3;
  localparam int UPT = 7;

  logic clk, nrst, ce;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DW-1:0] s_axi_wdata, s_axi_rdata;
  logic [NBYTES-1:0] s_axi_wstrb;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic trans_req, trans_ready, trans_busy, trans_done, halt_req, flush_go;
  vss_event_t trans_kind;
  logic [SEL_W-1:0] stabilization_select;
  logic [FLUSH_W-1:0] halt_flush_delay;
  logic [FLUSH_W-1:0] flush_early;
  int n_mismatch, tests_run;

  vss_top #(.REVISION(1)) u_vss_top (
    .clk(clk), .nrst(nrst), .ce(ce),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .trans_req(trans_req),
    .trans_kind(trans_kind), .trans_ready(trans_ready),
    .trans_busy(trans_busy), .trans_done(trans_done),
    .halt_req(halt_req), .flush_go(flush_go),
    .stabilization_select(stabilization_select),
    .halt_flush_delay(halt_flush_delay)
  );

  // Earliest revision twin on the same stimulus; its flush field stays dead
  vss_top #(.REVISION(REV_EARLIEST)) u_vss_top_early (
    .clk(clk), .nrst(nrst), .ce(ce),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(),
    .s_axi_rresp(), .trans_req(trans_req),
    .trans_kind(trans_kind), .trans_ready(),
    .trans_busy(), .trans_done(),
    .halt_req(halt_req), .flush_go(),
    .stabilization_select(),
    .halt_flush_delay(flush_early)
  );

  // Free-running clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic time_out(input string what);
    n_mismatch++;
    $display("mismatch %s exp answer got timeout", what);
    end_of_test();
  endtask

  // Readies are sampled at the falling edge; they only move on rising edges
  task automatic axi_write(input logic [AW-1:0] a, input logic [DW-1:0] d,
                           output logic [1:0] resp);
    logic aw_ok, w_ok, b_ok;
    int i;
    b_ok = 1'b0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !b_ok; i++) begin
      @(negedge clk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = (s_axi_bvalid === 1'b1);
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      if (b_ok) s_axi_bready <= 1'b0;
    end
    if (!b_ok) time_out("write response");
  endtask

  task automatic axi_read(input logic [AW-1:0] a, output logic [DW-1:0] d,
                          output logic [1:0] resp);
    logic ar_ok, r_ok;
    int i;
    r_ok = 1'b0;
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && !r_ok; i++) begin
      @(negedge clk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
      if (r_ok) s_axi_rready <= 1'b0;
    end
    if (!r_ok) time_out("read data");
  endtask

  // Request held for two edges: the second falls while busy and is refused
  task automatic fire(input logic halt, input vss_event_t k, output int n,
                      output int extra, output logic b1);
    logic seen;
    int i;
    n = -1;
    extra = 0;
    @(posedge clk);
    halt_req <= halt;
    trans_req <= !halt;
    trans_kind <= k;
    @(posedge clk);
    for (i = 1; i < 40; i++) begin
      @(posedge clk);
      if (i == 1) begin
        halt_req <= 1'b0;
        trans_req <= 1'b0;
      end
      #1;
      if (i == 1) b1 = trans_busy && !trans_ready;
      seen = halt ? flush_go : trans_done;
      if (seen === 1'b1 && n < 0) n = i;
      else if (seen === 1'b1) extra++;
    end
  endtask

  function automatic int exp_wait(input int s, input int k);
    if (k == 1) return UPT;
    if (k == 0) return (s == 2) ? 0 : MAINT;
    if (k == 2) return (s == 1) ? ALTT : (s == 3) ? MAINT : SHORT_WAIT_CYC_I;
    return (s == 3) ? MAINT : ALTT;
  endfunction

  task automatic t_reset();
    logic [DW-1:0] d;
    logic [1:0] r;
    axi_read(OFF_CFG, d, r);
    `CHK("cfg reset", ZERO_WORD, d);
    `CHK("flush out reset", RST_FLUSH, halt_flush_delay);
    `CHK("sel out reset", RST_SEL, stabilization_select);
    axi_read(OFF_MAIN_TIME, d, r);
    `CHK("main reset", {16'h0000, RST_MAIN_TIME}, d);
    axi_read(OFF_ALT_TIME, d, r);
    `CHK("alt reset", {16'h0000, RST_ALT_TIME}, d);
    `CHK("alt resp", RESP_OKAY, r);
    axi_read(OFF_UP_TIME, d, r);
    `CHK("up reset", {16'h0000, RST_UP_TIME}, d);
    axi_read(OFF_CTRL, d, r);
    `CHK("ctrl reset", ZERO_WORD, d);
    axi_read(OFF_STATUS, d, r);
    `CHK("status idle", ZERO_WORD, d);
    `CHK("ready idle", 1'b1, trans_ready);
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [DW-1:0] d;
    logic [1:0] r;
    // All ones: reserved bit 26 and bits outside fields must read 0
    axi_write(OFF_CFG, 32'hffff_ffff, r);
    `CHK("cfg wr resp", RESP_OKAY, r);
    axi_read(OFF_CFG, d, r);
    `CHK("cfg rd", 32'h1bf8_0000, d);
    `CHK("flush out", 7'h7f, halt_flush_delay);
    `CHK("early flush", RST_FLUSH, flush_early);
    axi_write(8'h40, 32'h0000_0001, r);
    `CHK("unmapped wr", RESP_SLVERR, r);
    axi_read(8'h40, d, r);
    `CHK("unmapped rresp", RESP_SLVERR, r);
    `CHK("unmapped rdata", ZERO_WORD, d);
    axi_write(OFF_CFG, ZERO_WORD, r);
    axi_read(OFF_CFG, d, r);
    `CHK("cfg clear", ZERO_WORD, d);
    $display("test registers done");
  endtask

  task automatic t_waits();
    logic [1:0] r;
    logic b1;
    int s, k, n, x, w;
    axi_write(OFF_MAIN_TIME, 32'h0000_0005, r);
    axi_write(OFF_ALT_TIME, 32'h0000_0003, r);
    axi_write(OFF_UP_TIME, 32'h0000_0007, r);
    for (s = 0; s < 4; s++) begin
      axi_write(OFF_CFG, {3'h0, s[1:0], 27'h0}, r);
      `CHK("sel out", s[1:0], stabilization_select);
      for (k = 0; k < 4; k++) begin
        w = exp_wait(s, k);
        fire(1'b0, vss_event_t'(k[1:0]), n, x, b1);
        `CHK("done cycle", w + 1, n);
        `CHK("extra done", 0, x);
        if (w > 0) `CHK("busy refusing", 1'b1, b1);
      end
    end
    $display("test waits done");
  endtask

  task automatic t_halt();
    logic [1:0] r;
    logic b1;
    int n, x;
    axi_write(OFF_CFG, 32'h0020_0000, r);
    `CHK("flush out 4", 7'h04, halt_flush_delay);
    axi_write(OFF_CTRL, ZERO_WORD, r);
    fire(1'b1, EV_DOWN, n, x, b1);
    `CHK("no flush when off", -1, n);
    axi_write(OFF_CTRL, 32'h0000_0001, r);
    fire(1'b1, EV_DOWN, n, x, b1);
    `CHK("flush go cycle", 5, n);
    `CHK("extra flush go", 0, x);
    $display("test halt done");
  endtask

  // Software policy: package types 0010 and 0100 get code 10, others 00
  task automatic t_policy();
    logic [1:0] r;
    logic [SEL_W-1:0] c;
    int p;
    for (p = 0; p < 16; p++) begin
      c = (p[3:0] == 4'h2 || p[3:0] == 4'h4) ? SEL_ZERO_SHORT_ALT : RST_SEL;
      // Codes below 11 rely on alt start id already matching core id
      axi_write(OFF_CFG, {3'h0, c, 27'h0}, r);
      `CHK("policy sel", c, stabilization_select);
    end
    $display("test policy done");
  endtask

  // Clock enable low for four edges stretches the wait by four cycles
  task automatic t_freeze();
    logic [1:0] r;
    logic b1;
    int n, x;
    axi_write(OFF_CFG, ZERO_WORD, r);
    fork
      fire(1'b0, EV_UP, n, x, b1);
      begin
        repeat (3) @(posedge clk);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
    `CHK("frozen done", UPT + 5, n);
    `CHK("frozen extra", 0, x);
    `CHK("frozen busy", 1'b1, b1);
    $display("test freeze done");
  endtask

  // Reset in mid-run returns the configuration to its cold values
  task automatic t_midreset();
    logic [DW-1:0] d;
    logic [1:0] r;
    axi_write(OFF_CFG, 32'hffff_ffff, r);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    axi_read(OFF_CFG, d, r);
    `CHK("cfg after reset", ZERO_WORD, d);
    `CHK("flush after reset", RST_FLUSH, halt_flush_delay);
    $display("test mid reset done");
  endtask

  // Reset for three cycles, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = '0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = '0;
    s_axi_rready = 1'b0;
    trans_req = 1'b0;
    trans_kind = EV_DOWN;
    halt_req = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_waits();
    t_halt();
    t_policy();
    t_freeze();
    t_midreset();
    end_of_test();
  end
endmodule

`default_nettype wire
